// File: shared/embp_pkg.sv
/*
 Constants and types for the external memory bus pin stage.
 Assumes one rising-edge system clock and a synchronous active-low reset.
*/
// Overview of operation
// - All memory bus pins except the SDRAM clock update and sample on the rising system clock edge.
// - Address output holds last access address while bus idle.
// - Bus exception taken through two synchroniser stages at the read data edge; asserted raises memory error.
// - I/O access ends two edges after io_ready_n is first sampled low, through two synchroniser stages.
// - Low seven checkbit lines carry EDAC bits; top line carries test bit.
// - Checkbit lines driven only on writes to EDAC protected areas.
// - Data bus driven only during write cycles.
// - Eight-bit areas transfer only on the top byte lane.
// - First PROM select below boundary address, second at or above it.
// - Four byte-lane write strobes; strobe zero governs bits 31 to 24.
// - Five SRAM bank selects and five SRAM bank output enables.
// - Read cycles assert output enable low and read strobe high.
// - Write cycles assert the write strobe low.
// - I/O area accesses assert the I/O select.
// - Two SDRAM bank selects; row, column, write strobes shared.
// - Four SDRAM data mask lines shared by both banks.
// - SDRAM clock in phase or inverted by configuration.
// - Both SDRAM clock enables permanently high.
// - System reset resets the memory bus logic.
`default_nettype none
package embp_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W   = 28;
    localparam int DATA_W   = 32;
    localparam int CB_W     = 8;
    localparam int EDAC_W   = 7;
    localparam int LANES    = 4;
    localparam int RAM_BANKS = 5;
    localparam int SD_BANKS = 2;
    // ----------------------------------------
    // Address map and reset values
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] PROM_HALF = 28'h0000000;
    localparam logic [31:0] PROM_BOUNDARY   = 32'h10000000;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 28'h0000000;
    localparam logic [DATA_W-1:0] DATA_RST  = 32'h00000000;
    localparam logic [CB_W-1:0]   CB_RST    = 8'h00;
    localparam logic [LANES-1:0]  LANE_OFF  = 4'hF;
    localparam logic [RAM_BANKS-1:0] RAM_OFF = 5'h1F;
    localparam logic [SD_BANKS-1:0] SD_OFF  = 2'h3;
    localparam logic [SD_BANKS-1:0] CKE_ON  = 2'h3;
    localparam int TOP_LANE_LO = 24;
    // ----------------------------------------
    // Area codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        EMBP_AREA_PROM,
        EMBP_AREA_SRAM,
        EMBP_AREA_IO,
        EMBP_AREA_SDRAM
    } embp_area_t;
    // SDRAM command on row, column, write strobes
    localparam logic [2:0] SD_CMD_NOP = 3'h7;
endpackage
`default_nettype wire

// File: rtl/embp_sdram_clock_out.sv
/*
 SDRAM clock output stage: in-phase or inverted copy of the system clock.
 Assumes the select is a static configuration level.
*/
`timescale 1ns/1ns
`default_nettype none
module embp_sdram_clock_out (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // Configuration
    input  wire logic invert,
    // Clock out
    output var  logic sdram_clock_out
);
    import embp_pkg::*;
    // ----------------------------------------
    // Select register
    // ----------------------------------------
    logic inv_ff;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            inv_ff <= 1'b0;
        end else begin
            inv_ff <= invert;
        end
    end
    // Output follows or inverts the clock
    always_comb begin
        sdram_clock_out = mclk ^ inv_ff;
    end
endmodule
`default_nettype wire

// File: rtl/embp_pins.sv
/*
 External memory bus pin stage of the memory controller.
 Assumes the controller core presents one access request per cycle on
 req_* while the bus is idle, and that io_ready_n and bus_exception_n
 arrive from off-chip pins.
*/
`timescale 1ns/1ns
`default_nettype none
module embp_pins (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          system_reset_n,
    // Controller request
    input  wire logic                          req_valid,
    input  wire logic                          req_write,
    input  wire embp_pkg::embp_area_t          req_area,
    input  wire logic [embp_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [31:0]                   req_full_addr,
    input  wire logic [embp_pkg::DATA_W-1:0]   req_wdata,
    input  wire logic [embp_pkg::LANES-1:0]    req_lanes,
    input  wire logic                          req_byte_area,
    input  wire logic                          req_edac,
    input  wire logic [embp_pkg::EDAC_W-1:0]   req_checkbits,
    input  wire logic [2:0]                    req_bank,
    input  wire logic                          req_sd_bank,
    input  wire logic [2:0]                    req_sd_cmd,
    // Configuration
    input  wire logic                          test_checkbit_field,
    input  wire logic                          sdram_clock_out_invert,
    // Controller answer
    output logic                               done,
    output logic                               mem_error,
    output logic [embp_pkg::DATA_W-1:0]        rdata,
    output logic [embp_pkg::CB_W-1:0]          rcheck,
    // Memory bus pins
    output logic [embp_pkg::ADDR_W-1:0]        addr_out,
    input  wire logic                          bus_exception_n,
    input  wire logic                          io_ready_n,
    input  wire logic [embp_pkg::CB_W-1:0]     checkbit_lines_in,
    output logic [embp_pkg::CB_W-1:0]          checkbit_lines_out,
    output logic                               checkbit_lines_oe,
    input  wire logic [embp_pkg::DATA_W-1:0]   data_in,
    output logic [embp_pkg::DATA_W-1:0]        data_out,
    output logic                               data_oe,
    output logic                               io_area_select_n,
    output logic                               mem_output_enable_n,
    output logic [embp_pkg::RAM_BANKS-1:0]     sram_bank_oe_n,
    output logic [embp_pkg::RAM_BANKS-1:0]     sram_bank_select_n,
    output logic                               read_strobe,
    output logic [1:0]                         prom_select_n,
    output logic [embp_pkg::LANES-1:0]         byte_lane_write_n,
    output logic                               write_strobe_n,
    // SDRAM pins
    output logic                               sdram_row_strobe_n,
    output logic                               sdram_col_strobe_n,
    output logic                               sdram_write_strobe_n,
    output logic [embp_pkg::SD_BANKS-1:0]      sdram_bank_select_n,
    output logic [embp_pkg::LANES-1:0]         sdram_data_mask_n,
    output logic [embp_pkg::SD_BANKS-1:0]      sdram_clock_enable,
    output var  logic                          sdram_clock_out
);
    import embp_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic rdy_s1_ff, rdy_s2_ff, bex_s1_ff, bex_s2_ff;
    always_ff @(posedge mclk) begin
        if (!system_reset_n) begin
            rdy_s1_ff <= 1'b1;
            rdy_s2_ff <= 1'b1;
            bex_s1_ff <= 1'b1;
            bex_s2_ff <= 1'b1;
        end else begin
            rdy_s1_ff <= io_ready_n;
            rdy_s2_ff <= rdy_s1_ff;
            bex_s1_ff <= bus_exception_n;
            bex_s2_ff <= bex_s1_ff;
        end
    end

    // ----------------------------------------
    // Access state
    // ----------------------------------------
    typedef enum logic [1:0] {EMBP_IDLE, EMBP_ACC, EMBP_IOWAIT} embp_st_t;
    embp_st_t st_ff, nxt_st;
    logic       wr_ff, edac_ff, byte_ff, io_arm_ff;
    embp_area_t area_ff;

    wire start    = (st_ff == EMBP_IDLE) && req_valid;
    wire is_io    = (req_area == EMBP_AREA_IO);
    // First wait cycle still holds the previous I/O access's ready
    wire io_go    = (st_ff == EMBP_IOWAIT) && io_arm_ff && !rdy_s2_ff;
    wire acc_end  = (st_ff == EMBP_ACC) || io_go;
    wire active_n = !(start || ((st_ff != EMBP_IDLE) && !acc_end));

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            EMBP_IDLE:   if (req_valid) nxt_st = is_io ? EMBP_IOWAIT : EMBP_ACC;
            EMBP_ACC:    nxt_st = EMBP_IDLE;
            EMBP_IOWAIT: if (io_go) nxt_st = EMBP_IDLE;
            default:     nxt_st = EMBP_IDLE;
        endcase
    end

    // ----------------------------------------
    // Strobe decode for the new access
    // ----------------------------------------
    wire [RAM_BANKS-1:0] bank_hot;
    genvar gi;
    generate
        for (gi = 0; gi < RAM_BANKS; gi++) begin : g_bank
            assign bank_hot[gi] = (req_bank == 3'(gi));
        end
    endgenerate
    wire prom_hi    = (req_full_addr >= PROM_BOUNDARY);
    wire is_prom    = start && req_area == EMBP_AREA_PROM;
    wire is_sram    = start && req_area == EMBP_AREA_SRAM;
    wire is_sd      = start && req_area == EMBP_AREA_SDRAM;
    wire new_rd     = start && !req_write;
    wire new_wr     = start && req_write;
    wire [1:0] nxt_prom = is_prom ? (prom_hi ? 2'h1 : 2'h2) : 2'h3;
    wire [RAM_BANKS-1:0] nxt_ram = is_sram ? ~bank_hot : RAM_OFF;
    wire [LANES-1:0] lanes = req_byte_area ? 4'h8 : req_lanes;
    // Lane 3 of the request maps to strobe 0, data bits 31 to 24
    wire [LANES-1:0] nxt_bwr =
        (new_wr && !is_sd) ? ~{lanes[0], lanes[1], lanes[2], lanes[3]}
                           : LANE_OFF;
    wire [DATA_W-1:0] wdata_sel =
        req_byte_area ? {req_wdata[7:0], 24'h000000} : req_wdata;

    // ----------------------------------------
    // Pin registers
    // ----------------------------------------
    logic [2:0] sd_cmd_ff;
    always_ff @(posedge mclk) begin
        if (!system_reset_n) begin
            st_ff               <= EMBP_IDLE;
            wr_ff               <= 1'b0;
            edac_ff             <= 1'b0;
            byte_ff             <= 1'b0;
            io_arm_ff           <= 1'b0;
            area_ff             <= EMBP_AREA_PROM;
            addr_out            <= ADDR_RST;
            data_out            <= DATA_RST;
            data_oe             <= 1'b0;
            checkbit_lines_out  <= CB_RST;
            checkbit_lines_oe   <= 1'b0;
            io_area_select_n    <= 1'b1;
            mem_output_enable_n <= 1'b1;
            read_strobe         <= 1'b0;
            write_strobe_n      <= 1'b1;
            sram_bank_oe_n      <= RAM_OFF;
            sram_bank_select_n  <= RAM_OFF;
            prom_select_n       <= 2'h3;
            byte_lane_write_n   <= LANE_OFF;
            sd_cmd_ff           <= SD_CMD_NOP;
            sdram_bank_select_n <= SD_OFF;
            sdram_data_mask_n   <= LANE_OFF;
            sdram_clock_enable  <= CKE_ON;
            done                <= 1'b0;
            mem_error           <= 1'b0;
            rdata               <= DATA_RST;
            rcheck              <= CB_RST;
        end else begin
            st_ff <= nxt_st;
            io_arm_ff <= (st_ff == EMBP_IOWAIT) && !io_go;
            sdram_clock_enable <= CKE_ON;
            if (start) begin
                wr_ff    <= req_write;
                edac_ff  <= req_edac;
                byte_ff  <= req_byte_area;
                area_ff  <= req_area;
                addr_out <= req_addr;
                data_out <= wdata_sel;
                checkbit_lines_out <= {test_checkbit_field,
                                       req_checkbits};
                data_oe  <= req_write;
                checkbit_lines_oe <= req_write && req_edac;
                io_area_select_n <= !is_io;
                mem_output_enable_n <= !new_rd;
                read_strobe <= new_rd;
                write_strobe_n <= !new_wr;
                sram_bank_oe_n <= new_rd ? nxt_ram : RAM_OFF;
                sram_bank_select_n <= nxt_ram;
                prom_select_n <= nxt_prom;
                byte_lane_write_n <= nxt_bwr;
                sd_cmd_ff <= is_sd ? req_sd_cmd : SD_CMD_NOP;
                sdram_bank_select_n <= is_sd
                    ? (req_sd_bank ? 2'h1 : 2'h2) : SD_OFF;
                sdram_data_mask_n <= is_sd ? ~req_lanes : LANE_OFF;
            end else if (active_n) begin
                data_oe             <= 1'b0;
                checkbit_lines_oe   <= 1'b0;
                io_area_select_n    <= 1'b1;
                mem_output_enable_n <= 1'b1;
                read_strobe         <= 1'b0;
                write_strobe_n      <= 1'b1;
                sram_bank_oe_n      <= RAM_OFF;
                sram_bank_select_n  <= RAM_OFF;
                prom_select_n       <= 2'h3;
                byte_lane_write_n   <= LANE_OFF;
                sd_cmd_ff           <= SD_CMD_NOP;
                sdram_bank_select_n <= SD_OFF;
                sdram_data_mask_n   <= LANE_OFF;
            end
            done <= acc_end;
            // Read data sampled at this edge; exception from the second synchroniser stage, two edges older
            mem_error <= acc_end && !wr_ff && !bex_s2_ff;
            if (acc_end && !wr_ff) begin
                rdata  <= byte_ff ? {24'h000000, data_in[31:24]}
                                  : data_in;
                rcheck <= edac_ff ? checkbit_lines_in : CB_RST;
            end
        end
    end

    always_comb begin
        {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n} =
            sd_cmd_ff;
    end

    // ----------------------------------------
    // SDRAM clock
    // ----------------------------------------
    embp_sdram_clock_out u_sdram_clock_out (
        .mclk            (mclk),
        .nrst            (system_reset_n),
        .invert          (sdram_clock_out_invert),
        .sdram_clock_out (sdram_clock_out)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!system_reset_n);

    property p_addr_hold;
        !start |=> $stable(addr_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
    property p_bexc;
        (done && !wr_ff && $past(system_reset_n, 3)) |->
            (mem_error == !$past(bus_exception_n, 3));
    endproperty
    a_bexc: assert property (p_bexc) else $error("error lost");
    property p_io_end;
        io_go |=> done && (st_ff == EMBP_IDLE);
    endproperty
    a_io_end: assert property (p_io_end) else $error("io not ended");
    property p_cb_drive;
        checkbit_lines_oe |-> (data_oe && !write_strobe_n);
    endproperty
    a_cb_drive: assert property (p_cb_drive) else $error("cb on read");
    property p_data_drive;
        data_oe |-> !write_strobe_n && read_strobe == 1'b0;
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("d on read");
    property p_rd_pair;
        read_strobe == !mem_output_enable_n;
    endproperty
    a_rd_pair: assert property (p_rd_pair) else $error("oe mismatch");
    property p_prom;
        is_prom |=> prom_select_n ==
            (($past(req_full_addr) < PROM_BOUNDARY) ? 2'h2 : 2'h1);
    endproperty
    a_prom: assert property (p_prom) else $error("prom half");
    property p_cke;
        sdram_clock_enable == CKE_ON;
    endproperty
    a_cke: assert property (p_cke) else $error("cke low");
    property p_idle;
        (st_ff == EMBP_IDLE && !start) |=> (st_ff != EMBP_IDLE) ||
            (write_strobe_n && sram_bank_select_n == RAM_OFF);
    endproperty
    a_idle: assert property (p_idle) else $error("idle strobe");

    c_read:  cover property (new_rd ##1 done);
    c_write: cover property (new_wr && req_edac ##1 checkbit_lines_oe);
    c_io:    cover property (start && is_io ##[1:20] io_go);
    c_err:   cover property (mem_error);
endmodule
`default_nettype wire

// File: tb/embp_mem_model.sv
/*
 External memory and I/O device model facing the pin stage.
 Assumes the bench sets the exception level and the I/O wait count.
*/
`timescale 1ns/1ns
`default_nettype none
module embp_mem_model (
    // Clock
    input  wire logic        mclk,
    // Pins from the pin stage
    input  wire logic [27:0] addr_out,
    input  wire logic        mem_output_enable_n,
    input  wire logic        data_oe,
    input  wire logic [31:0] data_out,
    input  wire logic        checkbit_lines_oe,
    input  wire logic [7:0]  checkbit_lines_out,
    input  wire logic        io_area_select_n,
    // Bench controls
    input  wire logic        exc_on,
    input  wire logic [1:0]  io_wait,
    // Pins back to the pin stage
    output var  logic [31:0] data_in,
    output var  logic [7:0]  checkbit_lines_in,
    output var  logic        bus_exception_n,
    output var  logic        io_ready_n
);
    logic [31:0] last_d;
    logic [7:0]  last_c;
    logic [2:0]  io_cnt;
    // ----------------------------------------
    // Bus resolution
    // ----------------------------------------
    always_comb begin
        if (data_oe)
            data_in = data_out;
        else if (!mem_output_enable_n)
            data_in = {4'h9, addr_out};
        else
            data_in = ~last_d;
        if (checkbit_lines_oe)
            checkbit_lines_in = checkbit_lines_out;
        else if (!mem_output_enable_n)
            checkbit_lines_in = addr_out[7:0];
        else
            checkbit_lines_in = ~last_c;
    end
    always_ff @(posedge mclk) begin
        last_d <= data_in;
        last_c <= checkbit_lines_in;
        io_cnt <= io_area_select_n ? 3'h0 : io_cnt + 3'h1;
    end
    // ----------------------------------------
    // Exception and ready pins
    // ----------------------------------------
    assign bus_exception_n = ~exc_on;
    assign io_ready_n = !(!io_area_select_n && io_cnt >= {1'b0, io_wait});
endmodule
`default_nettype wire

// File: tb/test_external_memory_bus_pins.sv
/*
 Self-checking bench for the memory bus pin stage.
 Assumes the device model of embp_mem_model on the far side.
*/
`timescale 1ns/1ns
`default_nettype none
module test_external_memory_bus_pins;
    import embp_pkg::*;
    logic mclk = 0, system_reset_n = 0, req_valid = 0, req_write = 0;
    embp_area_t req_area = EMBP_AREA_PROM;
    logic [27:0] req_addr = '0;
    logic [31:0] req_full_addr = '0, req_wdata = '0, rnd = 32'hd8e6;
    logic [3:0] req_lanes = '0;
    logic req_byte_area = 0, req_edac = 0, req_sd_bank = 0, exc_on = 0;
    logic [6:0] req_checkbits = '0;
    logic [2:0] req_bank = '0, req_sd_cmd = '0;
    logic test_checkbit_field = 0, sdram_clock_out_invert = 0;
    logic [1:0] io_wait = '0;
    logic done, mem_error, checkbit_lines_oe, data_oe, io_area_select_n;
    logic mem_output_enable_n, read_strobe, write_strobe_n, sdram_clock_out;
    logic sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n;
    logic [31:0] rdata, data_in, data_out;
    logic [7:0] rcheck, checkbit_lines_in, checkbit_lines_out;
    logic [27:0] addr_out;
    logic bus_exception_n, io_ready_n;
    logic [4:0] sram_bank_oe_n, sram_bank_select_n;
    logic [1:0] prom_select_n, sdram_bank_select_n, sdram_clock_enable;
    logic [3:0] byte_lane_write_n, sdram_data_mask_n;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    always #4 mclk = ~mclk;
    embp_pins uut (.mclk(mclk), .system_reset_n(system_reset_n), .req_valid(req_valid),
        .req_write(req_write), .req_area(req_area), .req_addr(req_addr),
        .req_full_addr(req_full_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
        .req_byte_area(req_byte_area), .req_edac(req_edac),
        .req_checkbits(req_checkbits), .req_bank(req_bank),
        .req_sd_bank(req_sd_bank), .req_sd_cmd(req_sd_cmd),
        .test_checkbit_field(test_checkbit_field), .sdram_clock_out_invert(sdram_clock_out_invert),
        .done(done), .mem_error(mem_error), .rdata(rdata), .rcheck(rcheck),
        .addr_out(addr_out), .bus_exception_n(bus_exception_n),
        .io_ready_n(io_ready_n), .checkbit_lines_in(checkbit_lines_in),
        .checkbit_lines_out(checkbit_lines_out), .checkbit_lines_oe(checkbit_lines_oe),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .io_area_select_n(io_area_select_n), .mem_output_enable_n(mem_output_enable_n),
        .sram_bank_oe_n(sram_bank_oe_n), .sram_bank_select_n(sram_bank_select_n),
        .read_strobe(read_strobe), .prom_select_n(prom_select_n),
        .byte_lane_write_n(byte_lane_write_n), .write_strobe_n(write_strobe_n),
        .sdram_row_strobe_n(sdram_row_strobe_n), .sdram_col_strobe_n(sdram_col_strobe_n),
        .sdram_write_strobe_n(sdram_write_strobe_n),
        .sdram_bank_select_n(sdram_bank_select_n), .sdram_data_mask_n(sdram_data_mask_n),
        .sdram_clock_enable(sdram_clock_enable), .sdram_clock_out(sdram_clock_out));
    embp_mem_model mem (.mclk(mclk), .addr_out(addr_out),
        .mem_output_enable_n(mem_output_enable_n), .data_oe(data_oe),
        .data_out(data_out), .checkbit_lines_oe(checkbit_lines_oe),
        .checkbit_lines_out(checkbit_lines_out), .io_area_select_n(io_area_select_n),
        .exc_on(exc_on), .io_wait(io_wait), .data_in(data_in),
        .checkbit_lines_in(checkbit_lines_in), .bus_exception_n(bus_exception_n),
        .io_ready_n(io_ready_n));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [3:0] exp_lanes(input logic [3:0] l);
        return ~{l[0], l[1], l[2], l[3]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic idle_chk(input logic [27:0] a);
        chk(32'(addr_out), 32'(a));
        chk(32'({mem_output_enable_n, read_strobe, write_strobe_n, io_area_select_n,
            prom_select_n, sram_bank_select_n, sram_bank_oe_n, byte_lane_write_n,
            sdram_bank_select_n}), 32'({4'hB, 18'h3FFFF}));
        chk(32'({data_oe, checkbit_lines_oe}), 32'h0);
        chk(32'({sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n}),
            32'(SD_CMD_NOP));
        chk(32'(sdram_clock_enable), 32'h3);
    endtask
    // ----------------------------------------
    // One access with strobe and answer checks
    // ----------------------------------------
    task automatic access(input logic wr, input embp_area_t ar, input logic [31:0] fa);
        logic [31:0] r;
        logic ex, bya;
        int n;
        logic rdy;
        rnd = lfsr(rnd);
        r = rnd;
        bya = r[4] & r[5] & (ar == EMBP_AREA_PROM || ar == EMBP_AREA_SRAM);
        ex = ~wr & r[7] & r[8];
        @(posedge mclk);
        exc_on <= ex;
        @(posedge mclk);
        req_valid <= 1;
        req_write <= wr;
        req_area <= ar;
        req_addr <= fa[27:0];
        req_full_addr <= fa;
        req_wdata <= r;
        req_lanes <= r[3:0];
        req_byte_area <= bya;
        req_edac <= r[6];
        req_bank <= (r[11:9] > 3'h4) ? {1'b0, r[10:9]} : r[11:9];
        req_sd_bank <= r[12];
        req_sd_cmd <= r[15:13];
        io_wait <= r[17:16];
        test_checkbit_field <= r[18];
        req_checkbits <= r[25:19];
        @(posedge mclk);
        req_valid <= 0;
        #1;
        chk(32'(addr_out), 32'(fa[27:0]));
        if (wr)
            chk(32'({write_strobe_n, data_oe, mem_output_enable_n, read_strobe}), 32'h6);
        else
            chk(32'({mem_output_enable_n, read_strobe, write_strobe_n, data_oe}), 32'h6);
        if (wr && bya)
            chk(32'(data_out[31:24]), 32'(r[7:0]));
        if (wr && !bya)
            chk(data_out, r);
        if (wr && !bya && ar != EMBP_AREA_SDRAM)
            chk(32'(byte_lane_write_n), 32'(exp_lanes(r[3:0])));
        chk(32'(checkbit_lines_oe), 32'(wr & r[6]));
        if (wr && r[6])
            chk(32'(checkbit_lines_out), 32'({r[18], r[25:19]}));
        case (ar)
            EMBP_AREA_PROM: chk(32'(prom_select_n), (fa < 32'h10000000) ? 32'h2 : 32'h1);
            EMBP_AREA_SRAM: begin
                chk(32'(sram_bank_select_n), 32'(5'(~(5'h1 << req_bank))));
                if (!wr)
                    chk(32'(sram_bank_oe_n), 32'(5'(~(5'h1 << req_bank))));
            end
            EMBP_AREA_IO: chk(32'(io_area_select_n), 32'h0);
            default: begin
                chk(32'(sdram_bank_select_n), 32'(2'(~(2'h1 << r[12]))));
                chk(32'(sdram_data_mask_n), 32'(4'(~r[3:0])));
                chk(32'({sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n}),
                    32'(r[15:13]));
            end
        endcase
        n = 0;
        rdy = 0;
        while (done !== 1'b1 && n < 30) begin
            @(posedge mclk);
            #1;
            n++;
            rdy = rdy | (io_ready_n === 1'b0);
        end
        chk(32'(done), 32'h1);
        if (ar == EMBP_AREA_IO)
            chk(32'(rdy), 32'h1);
        chk(32'(mem_error), 32'(ex));
        if (!wr) begin
            chk(rdata, bya ? {24'h000000, 4'h9, fa[27:24]}
                           : {4'h9, fa[27:0]});
            chk(32'(rcheck), r[6] ? 32'(fa[7:0]) : 32'h0);
        end
        @(posedge mclk);
        exc_on <= 0;
        @(posedge mclk);
        #1;
        idle_chk(fa[27:0]);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        system_reset_n <= 1;
        @(posedge mclk);
        #1;
        idle_chk(28'h0);
        chk(32'(sdram_clock_out), 32'h1);
        access(0, EMBP_AREA_PROM, 32'h0FFFFFFF);
        access(1, EMBP_AREA_PROM, 32'h10000000);
        for (int i = 0; i < 80; i++)
            access(rnd[0], embp_area_t'(rnd[2:1]), {3'h0, rnd[28:0]});
        @(posedge mclk);
        system_reset_n <= 0;
        repeat (2) @(posedge mclk);
        system_reset_n <= 1;
        #1;
        idle_chk(28'h0);
        access(0, EMBP_AREA_IO, 32'h00ABCDEF);
        @(posedge mclk);
        sdram_clock_out_invert <= 1;
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(sdram_clock_out), 32'h0);
        finish_test();
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
